// file: bem_monitor.sv
// Binary event monitor: a bank of three-state threshold classifiers with hysteresis.
// Assumes measurements and settings come from logic on clk; no synchroniser is needed.
//
// Function
// - Eleven channels: eight inputs, two resistive, one loop
// - Each channel is low, floating or high
// - Lower and upper thresholds bound the floating band
// - Each channel keeps its own thresholds
// - Separate hysteresis for lower and upper threshold
// - Hysteresis stops toggling near a threshold
// - Three state outputs per channel, one-hot
`timescale 1ns/1ps

`include "bem_defines.svh"

module bem_monitor
  import bem_pkg::*;
#(
  parameter int NCH = `BEM_NCH,
  parameter int MW = `BEM_MW
)
(
  input wire logic clk,
  input wire logic srst,
  // Converted measurements, channel i in bits [i*MW +: MW]
  input wire logic [NCH*MW-1:0] meas_in,
  // Lower threshold per channel
  input wire logic [NCH*MW-1:0] lo_thr,
  // Upper threshold per channel
  input wire logic [NCH*MW-1:0] hi_thr,
  // Hysteresis added to the lower threshold when leaving low
  input wire logic [NCH*MW-1:0] lo_hyst,
  // Hysteresis taken from the upper threshold when leaving high
  input wire logic [NCH*MW-1:0] hi_hyst,
  // State outputs, one bit per channel
  output logic [NCH-1:0] state_low,
  output logic [NCH-1:0] state_float,
  output logic [NCH-1:0] state_high
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // One channel and a two-bit measurement are the least the compares can serve
  if (NCH < 1 || MW < 2)
  begin : g_bad_param
    $error("bem_monitor: NCH must be at least 1 and MW at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State

  // Whole state of the block: one classifier state per channel
  typedef struct packed
  {
    bem_state_e [NCH-1:0] chan;
  } bem_regs_s;

  bem_regs_s state_reg;  // Registered state
  bem_regs_s state_next; // Next state

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel unpacking and hysteresis sums

  logic [MW-1:0] meas_ch [NCH];   // Measurement of each channel
  logic [MW-1:0] lo_ch [NCH];     // Lower threshold of each channel
  logic [MW-1:0] hi_ch [NCH];     // Upper threshold of each channel
  logic [MW:0] lo_up_ch [NCH];    // Lower threshold plus its hysteresis
  logic [MW:0] meas_up_ch [NCH];  // Measurement plus upper hysteresis

  // One extra bit keeps the sums from wrapping, so a large hysteresis never
  // turns into a small one; the upper compare is moved to the measurement
  // side so that threshold minus hysteresis can never go below zero.
  for (genvar gi = 0; gi < NCH; gi++)
  begin : g_chan
    assign meas_ch[gi] = meas_in[gi*MW +: MW];
    assign lo_ch[gi] = lo_thr[gi*MW +: MW];
    assign hi_ch[gi] = hi_thr[gi*MW +: MW];
    assign lo_up_ch[gi] = {1'b0, lo_ch[gi]} + {1'b0, lo_hyst[gi*MW +: MW]};
    assign meas_up_ch[gi] = {1'b0, meas_ch[gi]} + {1'b0, hi_hyst[gi*MW +: MW]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Each channel moves on its own inputs only; from floating the plain
  // thresholds apply, while a latched low or high needs the input to pass the
  // threshold by its hysteresis before it lets go.
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < NCH; i++)
    begin
      case (state_reg.chan[i])
        // Low holds until the input clears lower threshold plus hysteresis
        BEM_LOW:
        begin
          if ({1'b0, meas_ch[i]} > lo_up_ch[i])
          begin
            state_next.chan[i] = (meas_ch[i] > hi_ch[i]) ? BEM_HIGH : BEM_FLOAT;
          end
          else
          begin
            state_next.chan[i] = BEM_LOW;
          end
        end
        // High holds until the input drops below upper threshold minus hysteresis
        BEM_HIGH:
        begin
          if (meas_up_ch[i] < {1'b0, hi_ch[i]})
          begin
            state_next.chan[i] = (meas_ch[i] < lo_ch[i]) ? BEM_LOW : BEM_FLOAT;
          end
          else
          begin
            state_next.chan[i] = BEM_HIGH;
          end
        end
        // Floating band lies between the two thresholds; low wins if they cross
        BEM_FLOAT:
        begin
          if (meas_ch[i] < lo_ch[i])
          begin
            state_next.chan[i] = BEM_LOW;
          end
          else if (meas_ch[i] > hi_ch[i])
          begin
            state_next.chan[i] = BEM_HIGH;
          end
          else
          begin
            state_next.chan[i] = BEM_FLOAT;
          end
        end
        // Any illegal code recovers to floating
        default:
        begin
          state_next.chan[i] = BEM_FLOAT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset puts every channel into floating, the state of an unconnected input
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        state_reg.chan[i] <= BEM_FLOAT;
      end
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Straight from the one-hot state flops, so exactly one is high per channel
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      state_low[i] = state_reg.chan[i][`BEM_BIT_LOW];
      state_float[i] = state_reg.chan[i][`BEM_BIT_FLOAT];
      state_high[i] = state_reg.chan[i][`BEM_BIT_HIGH];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions, one set per channel

  for (genvar ai = 0; ai < NCH; ai++)
  begin : g_chk
    sequence s_in_low;
      state_low[ai] && !state_float[ai] && !state_high[ai];
    endsequence
    sequence s_in_high;
      state_high[ai] && !state_float[ai] && !state_low[ai];
    endsequence
    sequence s_in_float;
      state_float[ai] && !state_low[ai] && !state_high[ai];
    endsequence

    a_state_one_hot: assert property (
      @(posedge clk) disable iff (srst)
      $onehot({state_low[ai], state_float[ai], state_high[ai]}))
      else $error("channel state outputs not one-hot");

    a_low_exit_guard: assert property (
      @(posedge clk) disable iff (srst)
      state_low[ai] ##1 !state_low[ai] |-> {1'b0, $past(meas_ch[ai])} > $past(lo_up_ch[ai]))
      else $error("low left without clearing lower threshold plus hysteresis");

    a_high_exit_guard: assert property (
      @(posedge clk) disable iff (srst)
      state_high[ai] ##1 !state_high[ai] |-> $past(meas_up_ch[ai]) < {1'b0, $past(hi_ch[ai])})
      else $error("high left without passing upper threshold minus hysteresis");

    a_float_to_low: assert property (
      @(posedge clk) disable iff (srst)
      s_in_float and (meas_ch[ai] < lo_ch[ai]) |=> s_in_low)
      else $error("floating input below lower threshold did not go low");

    a_float_to_high: assert property (
      @(posedge clk) disable iff (srst)
      s_in_float and (meas_ch[ai] > hi_ch[ai]) and (meas_ch[ai] >= lo_ch[ai]) |=> s_in_high)
      else $error("floating input above upper threshold did not go high");

    a_float_band_hold: assert property (
      @(posedge clk) disable iff (srst)
      s_in_float and (meas_ch[ai] >= lo_ch[ai]) and (meas_ch[ai] <= hi_ch[ai]) |=> s_in_float)
      else $error("floating state left while input inside the band");

    a_low_hyst_hold: assert property (
      @(posedge clk) disable iff (srst)
      s_in_low and ({1'b0, meas_ch[ai]} <= lo_up_ch[ai]) |=> s_in_low)
      else $error("low state left inside lower hysteresis");

    a_high_hyst_hold: assert property (
      @(posedge clk) disable iff (srst)
      s_in_high and (meas_up_ch[ai] >= {1'b0, hi_ch[ai]}) |=> s_in_high)
      else $error("high state left inside upper hysteresis");
  end

endmodule

// file: bem_defines.svh
// Constants of the binary event monitor: channel count, measurement width, state codes.
// Assumes it is included by its bare name before the package that holds the types.
`ifndef BEM_DEFINES_SVH
`define BEM_DEFINES_SVH

// Eight analog/digital, two resistive and one current loop channel
`define BEM_NCH 11
// Width of one converted measurement and of each threshold or hysteresis setting
`define BEM_MW 12
// One-hot state codes, bit 0 low, bit 1 floating, bit 2 high
`define BEM_CODE_LOW 3'h1
`define BEM_CODE_FLOAT 3'h2
`define BEM_CODE_HIGH 3'h4
// Bit positions of the state codes
`define BEM_BIT_LOW 0
`define BEM_BIT_FLOAT 1
`define BEM_BIT_HIGH 2

`endif

// file: bem_pkg.sv
// Types shared by the binary event monitor.
// Assumes bem_defines.svh is on the include path.
`include "bem_defines.svh"

package bem_pkg;

  // Discrete state of one channel, one-hot
  typedef enum logic [2:0]
  {
    BEM_LOW = `BEM_CODE_LOW,
    BEM_FLOAT = `BEM_CODE_FLOAT,
    BEM_HIGH = `BEM_CODE_HIGH
  } bem_state_e;

endpackage

// file: bem_sink.sv
// Far-side model: switching logic that counts entries of all channels into HIGH in one total.
// Assumes state_high is registered on clk, as the monitor provides it.
`timescale 1ns/1ps
`include "bem_defines.svh"

module bem_sink
  import bem_pkg::*;
#(
  parameter int NCH = `BEM_NCH
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [NCH-1:0] state_high,
  output logic [7:0] high_entries
);
  // Last seen high flags, for edge detection
  logic [NCH-1:0] prev_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Rising-edge counter, like a counter element in edge mode
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Reset state of the monitor is FLOAT, so no edge is pending
      prev_reg <= '0;
      high_entries <= 8'h00;
    end
    else
    begin
      prev_reg <= state_high;
      high_entries <= high_entries + 8'($countones(state_high & ~prev_reg));
    end
  end
endmodule

// file: bem_monitor_test.sv
// Self-checking bench for the binary event monitor, all eleven channels.
// Assumes the monitor answers at the sampling edge, before the next falling edge.
`timescale 1ns/1ps
`include "bem_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module bem_monitor_test;
  import bem_pkg::*;
  localparam int N = `BEM_NCH;
  localparam int W = `BEM_MW;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [N*W-1:0] meas, lo, hi, lh, hh;
  logic [N-1:0] s_lo, s_fl, s_hi;
  logic [7:0] high_entries;
  bem_state_e exp_st [N];
  int fail_count = 0;
  int n_tests = 0;
  logic [W-1:0] thr_lo, thr_hi, hys_lo, hys_hi;

  always #12.5 clk = ~clk;

  bem_monitor dut (.clk(clk), .srst(srst), .meas_in(meas), .lo_thr(lo), .hi_thr(hi),
    .lo_hyst(lh), .hi_hyst(hh), .state_low(s_lo), .state_float(s_fl), .state_high(s_hi));
  bem_sink sink (.clk(clk), .srst(srst), .state_high(s_hi), .high_entries(high_entries));

  ////////////////////////////////////////////////////////////////////////////////
  // Drive one measurement at a falling edge, then check every channel's state
  task automatic apply(input int c, input logic [W-1:0] m, input bem_state_e e);
    logic [2:0] got;
    meas[c*W +: W] = m;
    exp_st[c] = e;
    @(negedge clk);
    // Whole bank compared, so a leak into a neighbour channel shows
    for (int i = 0; i < N; i++)
    begin
      got = {s_hi[i], s_fl[i], s_lo[i]};
      `CHK(got, exp_st[i])
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    // Distinct settings per channel: lower 100+i, upper 200+i, hysteresis 10 and 5+i
    for (int i = 0; i < N; i++)
    begin
      meas[i*W +: W] = 12'h096;
      lo[i*W +: W] = 12'h064 + i[W-1:0];
      hi[i*W +: W] = 12'h0C8 + i[W-1:0];
      lh[i*W +: W] = 12'h00A;
      hh[i*W +: W] = 12'h005 + i[W-1:0];
      exp_st[i] = BEM_FLOAT;
    end
    repeat (15) @(negedge clk);
    apply(0, 12'h096, BEM_FLOAT);
    srst = 1'b0;
    for (int c = 0; c < N; c++)
    begin
      thr_lo = lo[c*W +: W];
      thr_hi = hi[c*W +: W];
      hys_lo = lh[c*W +: W];
      hys_hi = hh[c*W +: W];
      apply(c, thr_lo - 12'h001, BEM_LOW);
      apply(c, thr_lo + hys_lo, BEM_LOW);
      apply(c, thr_lo + hys_lo + 12'h001, BEM_FLOAT);
      apply(c, thr_lo, BEM_FLOAT);
      apply(c, thr_hi, BEM_FLOAT);
      apply(c, thr_hi + 12'h001, BEM_HIGH);
      apply(c, thr_hi - hys_hi, BEM_HIGH);
      apply(c, thr_hi - hys_hi - 12'h001, BEM_FLOAT);
      apply(c, thr_hi + 12'h001, BEM_HIGH);
      apply(c, thr_lo - 12'h001, BEM_LOW);
      apply(c, thr_hi + 12'h001, BEM_HIGH);
      apply(c, 12'h096, BEM_FLOAT);
      $display("channel %0d done, mismatches %0d", c, fail_count);
    end
    // Three entries into HIGH per channel seen by the far side
    `CHK(high_entries, 8'h21)
    $display("sink check done");
    wrap_up();
  end
endmodule
